// ===== psptx_defines.vh
`ifndef PSPTX_DEFINES_VH
`define PSPTX_DEFINES_VH

// register word indices; the byte address on the bus is four times each
`define PSPTX_IDX_RSVD_A 6'h3E
`define PSPTX_IDX_RSVD_B 6'h3F
`define PSPTX_IDX_MODE 6'h00
`define PSPTX_IDX_TXSTATE 6'h01
`define PSPTX_IDX_STATUS 6'h02
`define PSPTX_IDX_SYMOUT 6'h03
`define PSPTX_IDX_SYMIN 6'h04

// field positions
`define PSPTX_MODE_DRIVE_BIT 0
`define PSPTX_STAT_PERR_BIT 0
`define PSPTX_STAT_DETECT_BIT 1
`define PSPTX_STAT_SELECT_BIT 2
`define PSPTX_STAT_ENABLE_BIT 3
`define PSPTX_SYMOUT_CTRL_BIT 8

// transmit state codes
`define PSPTX_TXSTATE_W 3
`define PSPTX_TXSTATE_OFF 3'h0

// reset values
`define PSPTX_RESET_TXSTATE 3'h0
`define PSPTX_RESET_RSVD 8'h00
// idle request word: parity set, control and symbols clear, odd in total
`define PSPTX_RESET_REQ 10'h200

// bus answers
`define PSPTX_RESP_OKAY 2'h0
`define PSPTX_RESP_SLVERR 2'h2

`endif

// ===== psptx_mac_model.sv
`timescale 1ns/1ns
`default_nettype none
module psptx_mac_model (
  input wire logic clk_sys,
  input wire logic [3:0] symA,
  input wire logic [3:0] symB,
  input wire logic ctl,
  input wire logic badPar,
  input wire logic lineOn,
  output var logic requestParityIn,
  output var logic requestCtrlFlag,
  output var logic [7:0] requestSymbolPair,
  output var logic linePresent,
  output var logic pmdSerialRx
);
  initial begin
    {requestParityIn, requestCtrlFlag, requestSymbolPair} = 10'h200;
    {linePresent, pmdSerialRx} = 2'h0;
  end
  // badPar breaks parity on purpose so the error flag can be provoked
  always @(posedge clk_sys) begin
    requestSymbolPair <= {symA, symB};
    requestCtrlFlag <= ctl;
    requestParityIn <= ~^{ctl, symA, symB} ^ badPar;
    linePresent <= lineOn;
    pmdSerialRx <= ~pmdSerialRx ^ symA[0];
  end
endmodule // psptx_mac_model
`default_nettype wire

// ===== psptx_pair_parity.v
`timescale 1ns/1ns
`default_nettype none

// odd parity bit for a 10-bit transfer: parity, control flag, two symbols
module psptx_pair_parity (
  input wire ctrlFlag,
  input wire [7:0] symbolPair,
  output wire parityBit
);

  // odd total: parity bit is the inverse of the xor of the other nine
  assign parityBit = ~(^{ctrlFlag, symbolPair});

endmodule // psptx_pair_parity

`default_nettype wire

// ===== psptx_properties.sv
`timescale 1ns/1ns
`default_nettype none
module psptx_properties (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] firstSymbol,
  input wire logic [3:0] secondSymbol,
  input wire logic pairIsControl,
  input wire logic indicateParityOut,
  input wire logic indicateCtrlFlag,
  input wire logic [7:0] indicateSymbolPair,
  input wire logic requestCtrlFlag,
  input wire logic [7:0] requestSymbolPair,
  input wire logic [7:0] forwardSymbolPair,
  input wire logic forwardCtrlFlag,
  input wire logic pmdSerialRx,
  input wire logic pmdSerialTx,
  input wire logic txEnablePolaritySelect,
  input wire logic pmdTxEnableOut,
  input wire logic [2:0] transmitStateCode
);
  // cycles since reset, so pipelines are judged only once filled
  logic [2:0] age_q;
  always @(posedge clk_sys) begin
    if (reset) age_q <= 3'h0;
    else if (age_q != 3'h7) age_q <= age_q + 3'h1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  sequence rdTaken; s_axi_arvalid && s_axi_arready; endsequence
  sequence rdDone; s_axi_rvalid && s_axi_rready; endsequence
  a_ind_pair_order: assert property (age_q != 3'h0 |->
    indicateSymbolPair == $past({firstSymbol, secondSymbol}))
    else $error("indicate pair order wrong");
  a_ind_ctrl_flag: assert property (age_q != 3'h0 |->
    indicateCtrlFlag == $past(pairIsControl)) else $error("ctrl flag wrong");
  a_ind_odd_parity: assert property (
    ^{indicateParityOut, indicateCtrlFlag, indicateSymbolPair})
    else $error("indicate parity not odd");
  a_fwd_pass_through: assert property (age_q > 3'h2 |->
    {forwardCtrlFlag, forwardSymbolPair} ==
    $past({requestCtrlFlag, requestSymbolPair}, 3))
    else $error("forwarded pair wrong");
  a_txe_off_inverse: assert property (
    age_q > 3'h2 && $past(transmitStateCode) == 3'h0 |->
    pmdTxEnableOut == !$past(txEnablePolaritySelect, 3))
    else $error("enable not inverse of select");
  a_serial_echo: assert property (age_q > 3'h2 |->
    pmdSerialTx == $past(pmdSerialRx, 3)) else $error("serial echo wrong");
  a_rd_answer: assert property (rdTaken |=> s_axi_rvalid)
    else $error("read not answered");
  a_rd_release: assert property (rdDone |=> !s_axi_rvalid)
    else $error("read answer not released");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=>
    !s_axi_bvalid) else $error("write answer not released");
endmodule // psptx_properties
bind psptx_symbol_port psptx_properties i_props (
  .clk_sys(clk_sys), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .firstSymbol(firstSymbol),
  .secondSymbol(secondSymbol), .pairIsControl(pairIsControl),
  .indicateParityOut(indicateParityOut),
  .indicateCtrlFlag(indicateCtrlFlag),
  .indicateSymbolPair(indicateSymbolPair),
  .requestCtrlFlag(requestCtrlFlag), .requestSymbolPair(requestSymbolPair),
  .forwardSymbolPair(forwardSymbolPair), .forwardCtrlFlag(forwardCtrlFlag),
  .pmdSerialRx(pmdSerialRx), .pmdSerialTx(pmdSerialTx),
  .txEnablePolaritySelect(txEnablePolaritySelect),
  .pmdTxEnableOut(pmdTxEnableOut), .transmitStateCode(transmitStateCode));
`default_nettype wire

// ===== psptx_symbol_port.v
`timescale 1ns/1ns
`default_nettype none
`include "psptx_defines.vh"

module psptx_symbol_port (
  input wire clk_sys,
  input wire reset,
  // axi4-lite slave
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // symbol source feeding the indicate path
  input wire [3:0] firstSymbol,
  input wire [3:0] secondSymbol,
  input wire pairIsControl,
  // indicate path out
  output wire indicateParityOut,
  output wire indicateCtrlFlag,
  output wire [7:0] indicateSymbolPair,
  // request path in
  input wire requestParityIn,
  input wire requestCtrlFlag,
  input wire [7:0] requestSymbolPair,
  // request path forwarded to the transmitter side
  output wire [7:0] forwardSymbolPair,
  output wire forwardCtrlFlag,
  // transceiver side
  input wire pmdSerialRx,
  output wire pmdSerialTx,
  input wire linePresent,
  input wire txEnablePolaritySelect,
  output wire pmdTxEnableOut,
  // transmit state code comes from the transmitter on this clock
  input wire [2:0] transmitStateCode
);

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function [5:0] wordIndex;
    input [7:0] byteAddr;
    begin
      wordIndex = byteAddr[7:2];
    end
  endfunction

  function oddParityOk;
    input par;
    input ctl;
    input [7:0] pair;
    begin
      oddParityOk = ^{par, ctl, pair};
    end
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  reg [1:0] selSync_q;
  reg [1:0] detSync_q;
  reg [1:0] rxSync_q;
  reg [9:0] reqStage1_q;
  reg [9:0] reqStage2_q;

  // request stages reset to an odd-parity idle word: an all-zero reset
  // would read as bad parity and raise a false error right after reset
  always @(posedge clk_sys) begin
    if (reset) begin
      selSync_q <= 2'h0;
      detSync_q <= 2'h0;
      rxSync_q <= 2'h0;
      reqStage1_q <= `PSPTX_RESET_REQ;
      reqStage2_q <= `PSPTX_RESET_REQ;
    end else begin
      selSync_q <= {selSync_q[0], txEnablePolaritySelect};
      detSync_q <= {detSync_q[0], linePresent};
      rxSync_q <= {rxSync_q[0], pmdSerialRx};
      reqStage1_q <= {requestParityIn, requestCtrlFlag, requestSymbolPair};
      reqStage2_q <= reqStage1_q;
    end
  end

  wire selLevel = selSync_q[1];

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg driveMode_q;
  reg parityErr_q;
  reg [7:0] rsvdA_q;
  reg [7:0] rsvdB_q;
  reg txEnable_q;
  reg indParity_q;
  reg indCtrl_q;
  reg [7:0] indPair_q;
  reg [7:0] fwdPair_q;
  reg fwdCtrl_q;
  reg serialTx_q;

  // ----------------------------------------------------------------
  // transmitter enable
  // ----------------------------------------------------------------
  // drive mode clear, or transmitter off: inverse of select; else follow
  wire txOff = (transmitStateCode == `PSPTX_TXSTATE_OFF);
  wire txEnable_d = (driveMode_q && !txOff) ? selLevel : ~selLevel;

  always @(posedge clk_sys) begin
    if (reset) begin
      txEnable_q <= 1'b0;
    end else begin
      txEnable_q <= txEnable_d;
    end
  end

  // ----------------------------------------------------------------
  // indicate path
  // ----------------------------------------------------------------
  wire indParity_d;

  psptx_pair_parity uParity (
    .ctrlFlag(pairIsControl),
    .symbolPair({firstSymbol, secondSymbol}),
    .parityBit(indParity_d)
  );

  always @(posedge clk_sys) begin
    if (reset) begin
      indParity_q <= 1'b1;
      indCtrl_q <= 1'b0;
      indPair_q <= 8'h00;
    end else begin
      indParity_q <= indParity_d;
      indCtrl_q <= pairIsControl;
      indPair_q <= {firstSymbol, secondSymbol};
    end
  end

  // ----------------------------------------------------------------
  // request path: check and forward
  // ----------------------------------------------------------------
  // bad parity is flagged only; symbols still go through unchanged
  wire reqBad = !oddParityOk(reqStage2_q[9], reqStage2_q[8],
    reqStage2_q[7:0]);

  always @(posedge clk_sys) begin
    if (reset) begin
      fwdPair_q <= 8'h00;
      fwdCtrl_q <= 1'b0;
      serialTx_q <= 1'b0;
    end else begin
      fwdPair_q <= reqStage2_q[7:0];
      fwdCtrl_q <= reqStage2_q[8];
      serialTx_q <= rxSync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  reg awHeld_q;
  reg wHeld_q;
  reg [7:0] awAddr_q;
  reg [31:0] wData_q;
  reg [3:0] wStrb_q;
  reg bValid_q;
  reg [1:0] bResp_q;
  reg awReady_q;
  reg wReady_q;

  // each ready is a flop holding the inverse of its channel's next busy
  // state, so no bus input reaches a bus output through logic
  wire awTake = s_axi_awvalid && awReady_q;
  wire wTake = s_axi_wvalid && wReady_q;
  wire doWrite = awHeld_q && wHeld_q && !bValid_q;
  wire awHeld_d = doWrite ? 1'b0 : (awTake ? 1'b1 : awHeld_q);
  wire wHeld_d = doWrite ? 1'b0 : (wTake ? 1'b1 : wHeld_q);
  wire bValid_d = doWrite ? 1'b1 :
    ((bValid_q && s_axi_bready) ? 1'b0 : bValid_q);
  wire [5:0] wIdx = wordIndex(awAddr_q);
  wire wMapped = (wIdx == `PSPTX_IDX_MODE) ||
    (wIdx == `PSPTX_IDX_STATUS) || (wIdx == `PSPTX_IDX_RSVD_A) ||
    (wIdx == `PSPTX_IDX_RSVD_B);
  wire clearPerr = doWrite && (wIdx == `PSPTX_IDX_STATUS) && wStrb_q[0] &&
    wData_q[`PSPTX_STAT_PERR_BIT];

  always @(posedge clk_sys) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      wStrb_q <= 4'h0;
      bValid_q <= 1'b0;
      bResp_q <= `PSPTX_RESP_OKAY;
      awReady_q <= 1'b1;
      wReady_q <= 1'b1;
      driveMode_q <= 1'b0;
      rsvdA_q <= `PSPTX_RESET_RSVD;
      rsvdB_q <= `PSPTX_RESET_RSVD;
    end else begin
      awReady_q <= !awHeld_d && !bValid_d;
      wReady_q <= !wHeld_d && !bValid_d;
      if (awTake) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bValid_q <= 1'b1;
        bResp_q <= wMapped ? `PSPTX_RESP_OKAY : `PSPTX_RESP_SLVERR;
        if (wIdx == `PSPTX_IDX_MODE && wStrb_q[0]) begin
          driveMode_q <= wData_q[`PSPTX_MODE_DRIVE_BIT];
        end
        // stored only so a careless write does no harm elsewhere
        if (wIdx == `PSPTX_IDX_RSVD_A && wStrb_q[0]) begin
          rsvdA_q <= wData_q[7:0];
        end
        if (wIdx == `PSPTX_IDX_RSVD_B && wStrb_q[0]) begin
          rsvdB_q <= wData_q[7:0];
        end
      end else if (bValid_q && s_axi_bready) begin
        bValid_q <= 1'b0;
      end
    end
  end

  // a new error in the clearing cycle wins over the clear
  always @(posedge clk_sys) begin
    if (reset) begin
      parityErr_q <= 1'b0;
    end else if (reqBad) begin
      parityErr_q <= 1'b1;
    end else if (clearPerr) begin
      parityErr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  reg rValid_q;
  reg [31:0] rData_q;
  reg [1:0] rResp_q;
  reg [31:0] rdMux;
  reg rdHit;
  reg arReady_q;

  wire arTake = s_axi_arvalid && arReady_q;
  wire rValid_d = arTake ? 1'b1 :
    ((rValid_q && s_axi_rready) ? 1'b0 : rValid_q);

  // only one read may be open: arready drops with the answer it makes
  always @(posedge clk_sys) begin
    if (reset) begin
      arReady_q <= 1'b1;
    end else begin
      arReady_q <= !rValid_d;
    end
  end

  always @* begin
    rdMux = 32'h00000000;
    rdHit = 1'b1;
    case (wordIndex(s_axi_araddr))
      `PSPTX_IDX_MODE: rdMux[`PSPTX_MODE_DRIVE_BIT] = driveMode_q;
      `PSPTX_IDX_TXSTATE: begin
        rdMux[`PSPTX_TXSTATE_W-1:0] = transmitStateCode;
      end
      `PSPTX_IDX_STATUS: begin
        rdMux[`PSPTX_STAT_PERR_BIT] = parityErr_q;
        rdMux[`PSPTX_STAT_DETECT_BIT] = detSync_q[1];
        rdMux[`PSPTX_STAT_SELECT_BIT] = selLevel;
        rdMux[`PSPTX_STAT_ENABLE_BIT] = txEnable_q;
      end
      `PSPTX_IDX_SYMOUT: begin
        rdMux[`PSPTX_SYMOUT_CTRL_BIT:0] = {indCtrl_q, indPair_q};
      end
      `PSPTX_IDX_SYMIN: begin
        rdMux[`PSPTX_SYMOUT_CTRL_BIT:0] = {fwdCtrl_q, fwdPair_q};
      end
      `PSPTX_IDX_RSVD_A: rdMux[7:0] = rsvdA_q;
      `PSPTX_IDX_RSVD_B: rdMux[7:0] = rsvdB_q;
      default: rdHit = 1'b0;
    endcase
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      rValid_q <= 1'b0;
      rData_q <= 32'h00000000;
      rResp_q <= `PSPTX_RESP_OKAY;
    end else if (arTake) begin
      rValid_q <= 1'b1;
      rData_q <= rdMux;
      rResp_q <= rdHit ? `PSPTX_RESP_OKAY : `PSPTX_RESP_SLVERR;
    end else if (rValid_q && s_axi_rready) begin
      rValid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign indicateParityOut = indParity_q;
  assign indicateCtrlFlag = indCtrl_q;
  assign indicateSymbolPair = indPair_q;
  assign forwardSymbolPair = fwdPair_q;
  assign forwardCtrlFlag = fwdCtrl_q;
  assign pmdSerialTx = serialTx_q;
  assign pmdTxEnableOut = txEnable_q;

endmodule // psptx_symbol_port

`default_nettype wire

// ===== tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "psptx_defines.vh"
module tb;
  localparam logic [7:0] aMode = {`PSPTX_IDX_MODE, 2'h0};
  localparam logic [7:0] aStat = {`PSPTX_IDX_STATUS, 2'h0};
  localparam logic [7:0] aSymIn = {`PSPTX_IDX_SYMIN, 2'h0};
  localparam logic [7:0] aRsvA = {`PSPTX_IDX_RSVD_A, 2'h0};
  localparam logic [7:0] aRsvB = {`PSPTX_IDX_RSVD_B, 2'h0};
  localparam logic [7:0] aTxSt = {`PSPTX_IDX_TXSTATE, 2'h0};
  localparam logic [7:0] aSymOut = {`PSPTX_IDX_SYMOUT, 2'h0};
  localparam logic [1:0] ok = `PSPTX_RESP_OKAY;
  logic clk_sys = 1'h0, reset = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ep, rqD, indD, fwdD;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [3:0] fs = 4'h0, ss = 4'h0, symA = 4'h0, symB = 4'h0;
  logic pc = 1'h0, ctl = 1'h0, badPar = 1'h0, lineOn = 1'h0, sel = 1'h0;
  logic [2:0] tsc = 3'h0;
  logic rqP, rqC, lineDet, srx, indP, indC, fwdC, stx, txEn, ex;
  int n_mismatch = 0, checks_done = 0, cyc = 0;
  psptx_symbol_port i_dut (.clk_sys(clk_sys), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .firstSymbol(fs),
    .secondSymbol(ss), .pairIsControl(pc), .indicateParityOut(indP),
    .indicateCtrlFlag(indC), .indicateSymbolPair(indD),
    .requestParityIn(rqP), .requestCtrlFlag(rqC), .requestSymbolPair(rqD),
    .forwardSymbolPair(fwdD), .forwardCtrlFlag(fwdC), .pmdSerialRx(srx),
    .pmdSerialTx(stx), .linePresent(lineDet), .txEnablePolaritySelect(sel),
    .pmdTxEnableOut(txEn), .transmitStateCode(tsc));
  psptx_mac_model i_mac (.clk_sys(clk_sys), .symA(symA), .symB(symB),
    .ctl(ctl), .badPar(badPar), .lineOn(lineOn), .requestParityIn(rqP),
    .requestCtrlFlag(rqC), .requestSymbolPair(rqD), .linePresent(lineDet),
    .pmdSerialRx(srx));
  initial forever #20 clk_sys = ~clk_sys;
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1);
    bready <= 1'h0;
    chk("bresp", ok, bresp);
  endtask
  // m masks the fields of interest in the returned word
  task automatic rd(input logic [7:0] a, input logic [31:0] m, e,
                    input logic [1:0] r);
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_sys);
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1);
    rready <= 1'h0;
    chk("rdata", e, rdata & m);
    chk("rresp", r, rresp);
  endtask
  initial begin
    tick(4);
    reset <= 1'h0;
    lineOn <= 1'h1;
    rd(aMode, 32'h1, 32'h0, ok);
    rd(aRsvA, 32'hFF, {24'h0, `PSPTX_RESET_RSVD}, ok);
    rd(aRsvB, 32'hFF, {24'h0, `PSPTX_RESET_RSVD}, ok);
    rd(8'h40, 32'hFFFFFFFF, 32'h0, `PSPTX_RESP_SLVERR);
    for (int i = 0; i < 8; i++) begin
      ep = 8'h1E * (i + 1);
      {fs, ss} <= ep;
      pc <= i[0];
      tick(2);
      chk("indPair", ep, indD);
      chk("indCtrl", i[0], indC);
      chk("indPar", ~^{i[0], ep}, indP);
      rd(aSymOut, 32'h1FF, {i[0], ep}, ok);
    end
    for (int i = 0; i < 2; i++) begin
      ep = 8'hC3 + i;
      {symA, symB} <= ep;
      ctl <= ~i[0];
      badPar <= i[0];
      tick(6);
      chk("fwdPair", {~i[0], ep}, {fwdC, fwdD});
      rd(aSymIn, 32'h1FF, {~i[0], ep}, ok);
      rd(aStat, 32'h3, {30'h0, 1'h1, i[0]}, ok);
    end
    badPar <= 1'h0;
    tick(6);
    wr(aStat, 32'h1);
    rd(aStat, 32'h1, 32'h0, ok);
    for (int m = 0; m < 2; m++) begin
      wr(aMode, m);
      for (int k = 0; k < 4; k++) begin
        tsc <= k[1] ? 3'h5 : `PSPTX_TXSTATE_OFF;
        sel <= k[0];
        ex = (m && k[1]) ? k[0] : !k[0];
        tick(5);
        chk("txEnable", ex, txEn);
        rd(aTxSt, 32'h7, k[1] ? 32'h5 : 32'h0, ok);
        rd(aStat, 32'hC, {28'h0, ex, k[0], 2'h0}, ok);
      end
    end
    stop_test();
  end
endmodule // tb
`default_nettype wire
